// file: hdl/clk_ctrl_defs.svh
`ifndef CLK_CTRL_DEFS_SVH
`define CLK_CTRL_DEFS_SVH

// Register offsets on the local register port (byte addresses, 16-bit words).
`define RA_SYS_CLK_CTRL 8'h00
`define RA_MODULE_STOP 8'h02
`define RA_CLK_PIN_DIR 8'h04
`define RA_STATUS 8'h06

// Field positions.
`define CLK_STOP_BIT 0
`define CLK_DIR_BIT 0
`define EXT_DMA_STOP_BIT 14
`define INT_DMA_STOP_BIT 13
`define TRANSFER_CTRL_STOP_BIT 12

// Status register layout.
`define ST_POWER_LSB 0
`define ST_PIN_LSB 4
`define ST_PIN_LEVEL_BIT 6
`define ST_REFUSED_LSB 8

// Reset values.
`define SYS_CLK_CTRL_RST 1'b0
`define CLK_PIN_DIR_RST 1'b0
`define MODULE_STOP_RST 16'h8fff
`define REFUSED_RST 3'h0

`endif

// file: hdl/clk_ctrl_pkg.sv
package clk_ctrl_pkg;

  // Processing state reported by the power manager.
  typedef enum logic [2:0] {
    PWR_NORMAL = 3'h0,
    PWR_SLEEP = 3'h1,
    PWR_ALL_CLK_STOP = 3'h3,
    PWR_SW_STANDBY = 3'h2,
    PWR_HW_STANDBY = 3'h6
  } power_state_type;

  // State of the clock output pin.
  typedef enum logic [1:0] {
    PIN_HIZ = 2'h0,
    PIN_RUN = 2'h1,
    PIN_HIGH = 2'h3
  } pin_state_type;

endpackage

// file: hdl/stop_ctrl_if.sv
`timescale 1ns/1ps
interface stop_ctrl_if #(parameter int NUM_MOD = 16);
  logic wr_req;
  logic [NUM_MOD-1:0] wr_data;
  logic cycle_end;
  logic [2:0] dma_active;
  logic [NUM_MOD-1:0] stop_bits;
  logic [2:0] refused;

  modport ctrl (output wr_req, output wr_data, output cycle_end, output dma_active,
                input stop_bits, input refused);
  modport unit (input wr_req, input wr_data, input cycle_end, input dma_active,
                output stop_bits, output refused);
endinterface // stop_ctrl_if

// file: hdl/module_stop_unit.sv
`timescale 1ns/1ps
`include "clk_ctrl_defs.svh"
module module_stop_unit #(
  parameter int NUM_MOD = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  stop_ctrl_if.unit bus
);

  logic [NUM_MOD-1:0] pending_r;
  logic [NUM_MOD-1:0] pending_nxt;
  logic [NUM_MOD-1:0] stop_r;
  logic [2:0] refused_r;
  logic [2:0] refused_nxt;
  logic [2:0] dma_bit_mask;

  // A written value is held here until the bus cycle ends.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pending_r <= `MODULE_STOP_RST;
    end else if (clk_en && bus.wr_req) begin
      pending_r <= bus.wr_data;
    end
  end

  // A busy controller keeps its stop bit low; only the set is refused.
  always_comb begin
    pending_nxt = pending_r;
    dma_bit_mask = 3'h0;
    if (bus.dma_active[2] && !stop_r[`EXT_DMA_STOP_BIT]) begin
      pending_nxt[`EXT_DMA_STOP_BIT] = 1'b0;
      dma_bit_mask[2] = pending_r[`EXT_DMA_STOP_BIT];
    end
    if (bus.dma_active[1] && !stop_r[`INT_DMA_STOP_BIT]) begin
      pending_nxt[`INT_DMA_STOP_BIT] = 1'b0;
      dma_bit_mask[1] = pending_r[`INT_DMA_STOP_BIT];
    end
    if (bus.dma_active[0] && !stop_r[`TRANSFER_CTRL_STOP_BIT]) begin
      pending_nxt[`TRANSFER_CTRL_STOP_BIT] = 1'b0;
      dma_bit_mask[0] = pending_r[`TRANSFER_CTRL_STOP_BIT];
    end
    refused_nxt = dma_bit_mask;
  end

  // Stop bits take effect only at the end of a bus cycle, so a module is
  // never cut off in the middle of an access.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stop_r <= `MODULE_STOP_RST;
      refused_r <= `REFUSED_RST;
    end else if (clk_en && bus.cycle_end) begin
      stop_r <= pending_nxt;
      refused_r <= refused_nxt;
    end
  end

  assign bus.stop_bits = stop_r;
  assign bus.refused = refused_r;

endmodule // module_stop_unit

// file: hdl/clock_output_and_module_stop_ctrl.sv
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "clk_ctrl_defs.svh"
module clock_output_and_module_stop_ctrl
  import clk_ctrl_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16,
  parameter int PORT_W = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic wr_from_cpu,
  output logic [DATA_W-1:0] rdata,
  input wire power_state_type power_state,
  input wire logic hw_standby_n,
  input wire logic bus_cycle_end,
  input wire logic [2:0] dma_active,
  input wire logic clk_pin_i,
  output logic clk_pin_o,
  output logic clk_pin_oe_n,
  input wire logic [PORT_W-1:0] port_out_req,
  output logic [PORT_W-1:0] port_out,
  output logic [DATA_W-1:0] module_stop,
  output logic [DATA_W-1:0] module_access_en
);

  // Decodes one register offset; used by both the write and read paths.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] off);
    reg_hit = (a == off);
  endfunction

  // Synchroniser stages for the pins.
  logic hws_s1_r;
  logic hws_s2_r;
  logic pin_s1_r;
  logic pin_s2_r;
  logic hw_stby;
  logic rst_all;

  // Software visible state.
  logic clock_output_stop_r;
  logic clk_dir_r;
  logic clk_stop_eff_r;

  // Pin generation.
  logic phase_r;
  pin_state_type pin_state_r;
  pin_state_type pin_state_nxt;
  logic clk_pin_o_r;
  logic clk_pin_o_nxt;
  logic clk_pin_oe_n_r;

  // Other outputs.
  logic [PORT_W-1:0] port_out_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic [DATA_W-1:0] access_en_r;
  logic mst_wr_ok;

  stop_ctrl_if #(.NUM_MOD(DATA_W)) stop_bus();

  // The standby pin comes from the board, so it passes two flops first.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hws_s1_r <= 1'b1;
      hws_s2_r <= 1'b1;
    end else if (clk_en) begin
      hws_s1_r <= hw_standby_n;
      hws_s2_r <= hws_s1_r;
    end
  end

  // The pin level in input mode is only shown in status, still synchronised.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else if (clk_en) begin
      pin_s1_r <= clk_pin_i;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Hardware standby puts every function except the pin synchronisers, the pin drive and read data flops into its reset state,
  // either from the pin or from the power manager's report.
  assign hw_stby = !hws_s2_r || (power_state == PWR_HW_STANDBY);
  assign rst_all = reset || hw_stby;

  // The module stop register ignores writes from DMA-type masters, which
  // would otherwise be able to stop themselves mid transfer.
  // CPU writes only
  assign mst_wr_ok = wr && wr_from_cpu && reg_hit(addr, `RA_MODULE_STOP);

  // Clock control and pin direction registers.
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      clock_output_stop_r <= `SYS_CLK_CTRL_RST;
      clk_dir_r <= `CLK_PIN_DIR_RST;
    end else if (clk_en && wr) begin
      if (reg_hit(addr, `RA_SYS_CLK_CTRL)) begin
        clock_output_stop_r <= wdata[`CLK_STOP_BIT];
      end
      if (reg_hit(addr, `RA_CLK_PIN_DIR)) begin
        clk_dir_r <= wdata[`CLK_DIR_BIT];
      end
    end
  end

  // The stop bit reaches the pin only when the bus cycle ends, so a stop
  // written mid cycle lets the cycle complete with its clock.
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      clk_stop_eff_r <= `SYS_CLK_CTRL_RST;
    end else if (clk_en && bus_cycle_end) begin
      clk_stop_eff_r <= clock_output_stop_r;
    end
  end

  // Phase of the output clock, which runs at half the flop rate because the
  // pin is driven from a flop.
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      phase_r <= 1'b0;
    end else if (clk_en) begin
      phase_r <= !phase_r;
    end
  end

  // Pin state selection, in priority order.
  always_comb begin
    pin_state_nxt = PIN_RUN;
    case (1'b1)
      !clk_dir_r: pin_state_nxt = PIN_HIZ;
      hw_stby: pin_state_nxt = PIN_HIZ;
      (power_state == PWR_SW_STANDBY): pin_state_nxt = PIN_HIGH;
      clk_stop_eff_r: pin_state_nxt = PIN_HIGH;
      default: pin_state_nxt = PIN_RUN;
    endcase
  end

  // Pin level follows the selected state; high whenever not running so the
  // board never sees a low that could be taken as a clock edge.
  always_comb begin
    case (pin_state_nxt)
      PIN_RUN: clk_pin_o_nxt = !phase_r;
      PIN_HIGH: clk_pin_o_nxt = 1'b1;
      PIN_HIZ: clk_pin_o_nxt = 1'b1;
      default: clk_pin_o_nxt = 1'b1;
    endcase
  end

  // Registered pin drive. The state is kept without the hardware standby
  // reset; the pin still goes hi-Z on the first clock edge after standby is seen.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_state_r <= PIN_HIZ;
      clk_pin_o_r <= 1'b1;
      clk_pin_oe_n_r <= 1'b1;
    end else if (clk_en) begin
      pin_state_r <= pin_state_nxt;
      clk_pin_o_r <= clk_pin_o_nxt;
      clk_pin_oe_n_r <= (pin_state_nxt == PIN_HIZ);
    end
  end

  // General port outputs freeze in software standby and keep driving their
  // level; this saves no output current, which is a known limitation.
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      port_out_r <= '0;
    end else if (clk_en && (power_state != PWR_SW_STANDBY)) begin
      port_out_r <= port_out_req;
    end
  end

  // Module stop unit hookup.
  assign stop_bus.wr_req = clk_en && mst_wr_ok;
  assign stop_bus.wr_data = wdata;
  assign stop_bus.cycle_end = bus_cycle_end;
  assign stop_bus.dma_active = dma_active;

  module_stop_unit #(
    .NUM_MOD(DATA_W)
  ) u_stop (
    .sys_clk(sys_clk),
    .reset(rst_all),
    .clk_en(clk_en),
    .bus(stop_bus.unit)
  );

  // A stopped module's registers are closed to the bus; software must mask
  // its interrupts first since a stopped module cannot clear a request.
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      access_en_r <= ~`MODULE_STOP_RST;
    end else if (clk_en) begin
      access_en_r <= ~stop_bus.stop_bits;
    end
  end

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    rdata_nxt = '0;
    if (reg_hit(addr, `RA_SYS_CLK_CTRL)) begin
      rdata_nxt[`CLK_STOP_BIT] = clock_output_stop_r;
    end else if (reg_hit(addr, `RA_MODULE_STOP)) begin
      rdata_nxt = stop_bus.stop_bits;
    end else if (reg_hit(addr, `RA_CLK_PIN_DIR)) begin
      rdata_nxt[`CLK_DIR_BIT] = clk_dir_r;
    end else if (reg_hit(addr, `RA_STATUS)) begin
      rdata_nxt[`ST_POWER_LSB +: 3] = power_state;
      rdata_nxt[`ST_PIN_LSB +: 2] = pin_state_r;
      rdata_nxt[`ST_PIN_LEVEL_BIT] = pin_s2_r;
      rdata_nxt[`ST_REFUSED_LSB +: 3] = stop_bus.refused;
    end
  end

  // Read data stands for exactly the cycle after the read strobe.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_r <= '0;
    end else if (clk_en) begin
      rdata_r <= rd ? rdata_nxt : '0;
    end
  end

  // Module stop bits go out through a second flop stage here, one cycle behind the unit's stop bits.
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      module_stop <= `MODULE_STOP_RST;
    end else if (clk_en) begin
      module_stop <= stop_bus.stop_bits;
    end
  end

  assign rdata = rdata_r;
  assign clk_pin_o = clk_pin_o_r;
  assign clk_pin_oe_n = clk_pin_oe_n_r;
  assign port_out = port_out_r;
  assign module_access_en = access_en_r;

endmodule // clock_output_and_module_stop_ctrl

// file: dv/clk_ctrl_asserts.sv
`timescale 1ns/1ps
`include "clk_ctrl_defs.svh"
module clk_ctrl_asserts
  import clk_ctrl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire power_state_type power_state,
  input wire logic bus_cycle_end,
  input wire logic [2:0] dma_active,
  input wire logic clk_pin_o,
  input wire logic clk_pin_oe_n,
  input wire logic [7:0] port_out,
  input wire logic [15:0] module_stop,
  input wire logic [15:0] module_access_en
);
  logic stop_r, dir_r, eff_r;
  wire hw = power_state == PWR_HW_STANDBY;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Shadow the pin bits; hardware standby clears them just as reset does.
  always_ff @(posedge sys_clk) begin
    if (reset || hw) begin
      stop_r <= 1'b0;
      dir_r <= 1'b0;
      eff_r <= 1'b0;
    end else begin
      if (wr && addr == `RA_SYS_CLK_CTRL) stop_r <= wdata[`CLK_STOP_BIT];
      if (wr && addr == `RA_CLK_PIN_DIR) dir_r <= wdata[`CLK_DIR_BIT];
      if (bus_cycle_end) eff_r <= stop_r; // The stop only bites at a cycle end.
    end
  end

  property p_dir_hiz;
    !dir_r |=> clk_pin_oe_n;
  endproperty
  a_dir_hiz: assert property (p_dir_hiz) else $error("pin driven while input");
  property p_run;
    (dir_r && !eff_r && power_state == PWR_NORMAL) [*3] |-> !clk_pin_oe_n && $changed(clk_pin_o);
  endproperty
  a_run: assert property (p_run) else $error("clock not running on pin");
  property p_stop_hi;
    (dir_r && eff_r && !hw) [*2] |-> clk_pin_o && !clk_pin_oe_n;
  endproperty
  a_stop_hi: assert property (p_stop_hi) else $error("stopped pin not high");
  property p_hw_hiz;
    hw [*2] |-> clk_pin_oe_n;
  endproperty
  a_hw_hiz: assert property (p_hw_hiz) else $error("pin driven in hw standby");
  property p_sw_hi;
    (power_state == PWR_SW_STANDBY) [*2] |-> clk_pin_o || clk_pin_oe_n;
  endproperty
  a_sw_hi: assert property (p_sw_hi) else $error("pin low in sw standby");
  property p_port_hold;
    $past(power_state) == PWR_SW_STANDBY |-> $stable(port_out);
  endproperty
  a_port_hold: assert property (p_port_hold) else $error("port moved in standby");
  property p_refuse;
    bus_cycle_end && !$past(bus_cycle_end) && dma_active[2] && !module_stop[14]
      |-> ##2 !module_stop[14];
  endproperty
  a_refuse: assert property (p_refuse) else $error("busy dma stopped");
  property p_stop_lat;
    $changed(module_stop) && !$past(hw) && !$past(hw, 2) |-> $past(bus_cycle_end, 2);
  endproperty
  a_stop_lat: assert property (p_stop_lat) else $error("stop moved off cycle end");
  property p_access;
    module_access_en == ~module_stop;
  endproperty
  a_access: assert property (p_access) else $error("stopped module reachable");
endmodule // clk_ctrl_asserts

bind clock_output_and_module_stop_ctrl clk_ctrl_asserts chk_i (.sys_clk(sys_clk),
  .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .power_state(power_state),
  .bus_cycle_end(bus_cycle_end), .dma_active(dma_active), .clk_pin_o(clk_pin_o),
  .clk_pin_oe_n(clk_pin_oe_n), .port_out(port_out), .module_stop(module_stop),
  .module_access_en(module_access_en));

// file: dv/board_clk_rx.sv
`timescale 1ns/1ps
module board_clk_rx (
  input wire logic pin_o,
  input wire logic pin_oe_n,
  output logic pin_level,
  output int edges
);
  // The board pulls the clock net up, so a released pin reads high.
  assign pin_level = pin_oe_n ? 1'b1 : pin_o;
  // Count rising edges; a halted clock must add none.
  initial edges = 0;
  always @(posedge pin_level) edges++;
endmodule // board_clk_rx

// file: dv/tb_clock_output_and_module_stop_ctrl.sv
`timescale 1ns/1ps
`include "clk_ctrl_defs.svh"
module tb_clock_output_and_module_stop_ctrl import clk_ctrl_pkg::*;;
  logic sys_clk = 0, reset = 1, wr = 0, rd = 0, cpu = 0, bce = 0;
  logic pin_o, pin_oe_n, pin_lvl;
  logic [7:0] addr = 8'h00, preq = 8'h00, port_out, pm;
  logic [15:0] wdata = 16'h0000, rdata, mstop, acc_en, v, ms_m, nm;
  logic [2:0] dma = 3'h0, ref3;
  logic [31:0] rs = 32'h287cdd3a;
  power_state_type ps = PWR_NORMAL;
  power_state_type ps_tab [5] = '{PWR_NORMAL, PWR_SLEEP, PWR_ALL_CLK_STOP, PWR_SW_STANDBY,
    PWR_HW_STANDBY};
  logic [15:0] st_tab [5] = '{16'h0010, 16'h0011, 16'h0013, 16'h0032, 16'h0006};
  int errors = 0, n_checks = 0, cyc = 0, edges, e0;

  always #2.5 sys_clk = ~sys_clk;

  clock_output_and_module_stop_ctrl dut (.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .wr_from_cpu(cpu), .rdata(rdata),
    .power_state(ps), .hw_standby_n(1'b1), .bus_cycle_end(bce), .dma_active(dma),
    .clk_pin_i(pin_lvl), .clk_pin_o(pin_o), .clk_pin_oe_n(pin_oe_n), .port_out_req(preq),
    .port_out(port_out), .module_stop(mstop), .module_access_en(acc_en));
  board_clk_rx board (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_level(pin_lvl), .edges(edges));

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic chk(input string nm_s, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm_s, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d, input logic c);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    cpu <= c;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic pulse_bce();
    @(posedge sys_clk);
    bce <= 1'b1;
    @(posedge sys_clk);
    bce <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Cut a hang short; the whole run needs well under a thousand cycles.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    ms_m = 16'h8fff;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    rd_reg(`RA_MODULE_STOP, v);
    chk("mstop_rst", v, ms_m);
    chk("access_rst", acc_en, 16'h7000);
    chk("pin_rst", {15'h0000, pin_oe_n}, 16'h0001);
    rd_reg(8'h08, v);
    chk("unmapped", v, 16'h0000);
    $display("test reset done");
    wr_reg(`RA_CLK_PIN_DIR, 16'h0001, 1'b1);
    repeat (4) @(posedge sys_clk);
    e0 = edges;
    repeat (20) @(posedge sys_clk);
    chk("run_edges", 16'(edges - e0), 16'h000a);
    wr_reg(`RA_SYS_CLK_CTRL, 16'h0001, 1'b1);
    pulse_bce();
    e0 = edges;
    repeat (10) @(posedge sys_clk);
    chk("stop_edges", 16'(edges - e0), 16'h0000);
    chk("stop_level", {15'h0000, pin_lvl}, 16'h0001);
    wr_reg(`RA_SYS_CLK_CTRL, 16'h0000, 1'b1);
    pulse_bce();
    $display("test pin done");
    // Random stop requests against random busy controllers; the model forces refused bits.
    // no interrupt source is ever pending here, so every stop request is legal.
    for (int i = 0; i < 8; i++) begin
      v = xs();
      nm = v;
      // a write from a DMA-type master must leave the register untouched.
      wr_reg(`RA_MODULE_STOP, ~v, 1'b0);
      wr_reg(`RA_MODULE_STOP, nm, 1'b1);
      rd_reg(`RA_MODULE_STOP, v);
      chk("pending", v, ms_m);
      ref3 = 3'(xs());
      dma <= ref3;
      ref3 = nm[14:12] & ref3 & ~ms_m[14:12];
      ms_m = nm & ~{1'b0, ref3, 12'h000};
      pulse_bce();
      chk("mstop_out", mstop, ms_m);
      chk("access", acc_en, ~ms_m);
      rd_reg(`RA_MODULE_STOP, v);
      chk("mstop_rd", v, ms_m);
      rd_reg(`RA_STATUS, v);
      chk("refused", v & 16'h0700, {5'h00, ref3, 8'h00});
    end
    $display("test module stop done");
    for (int i = 0; i < 5; i++) begin
      ps <= ps_tab[i];
      preq <= 8'(xs());
      #1;
      pm = (ps_tab[i] == PWR_SW_STANDBY) ? port_out : preq;
      pm = (ps_tab[i] == PWR_HW_STANDBY) ? 8'h00 : pm;
      repeat (3) @(posedge sys_clk);
      rd_reg(`RA_STATUS, v);
      chk("status", v & 16'h0037, st_tab[i]);
      chk("port", {8'h00, port_out}, {8'h00, pm});
      chk("pin_hiz", {15'h0000, pin_oe_n}, {15'h0000, st_tab[i][5:4] == 2'h0});
    end
    $display("test power done");
    close_out();
  end
endmodule // tb_clock_output_and_module_stop_ctrl
